// File: gen_seq_cfg.svh
`ifndef GEN_SEQ_CFG_SVH
`define GEN_SEQ_CFG_SVH

// Register byte offsets
`define OFF_CTRL 12'h000
`define OFF_TIMING 12'h004
`define OFF_STATUS 12'h008
`define OFF_CHARGE 12'h00C

// Control register fields
`define CTRL_FUNC_BIT 0
`define CTRL_START_BIT 1
`define CTRL_AUTO_STOP_BIT 2
`define CTRL_MANUAL_STOP_BIT 3
`define CTRL_ERR_CLR_BIT 4

// Reset values
`define CRANK_LIMIT_RST 8'h0A
`define GLOW_LEAD_RST 8'h05
`define RESTART_WAIT_RST 8'h0A
`define SAT_HOLD_RST 16'h0E10

// Fixed timing
`define MAX_ATTEMPTS 3'h5
`define COOL_DOWN_S 40
`define RUN_OK_S 300
`define CLK_HZ 250000000
`define HALF_SEC_CYC (`CLK_HZ / 2)

`endif

// File: gen_seq_pkg.sv
package gen_seq_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_GLOW, ST_CRANK, ST_CRANK_TAIL, ST_POST,
    ST_KILL, ST_COOL, ST_STOPPED
  } seq_state_t;

  typedef struct packed {
    logic run_stop_relay;
    logic starter_relay;
  } relay_t;

  typedef struct packed {
    logic [7:0] crank_limit;
    logic [7:0] glow_lead;
    logic [7:0] restart_wait_time;
  } timing_t;
endpackage

// File: half_sec_tick.sv
`timescale 1ns/1ps
`default_nettype none
`include "gen_seq_cfg.svh"

module half_sec_tick #(
  parameter int unsigned HALF_CYC = `HALF_SEC_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Ticks
  output logic half_tick,
  output logic sec_tick
);
  logic [31:0] cnt_reg;
  logic phase_reg;
  wire wrap = (cnt_reg == 32'(HALF_CYC - 1));

  // Half-second divider, second tick on every other half
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 32'h0000_0000;
      phase_reg <= 1'b0;
    end else if (wrap) begin
      cnt_reg <= 32'h0000_0000;
      phase_reg <= ~phase_reg;
    end else begin
      cnt_reg <= cnt_reg + 32'h0000_0001;
    end
  end

  assign half_tick = wrap;
  assign sec_tick = wrap & phase_reg;
endmodule
`default_nettype wire

// File: gen_seq.sv
`timescale 1ns/1ps
`default_nettype none
`include "gen_seq_cfg.svh"

module gen_seq
  import gen_seq_pkg::*;
#(
  parameter int unsigned HALF_CYC = `HALF_SEC_CYC,
  parameter int unsigned COOL_S = `COOL_DOWN_S,
  parameter int unsigned RUN_OK = `RUN_OK_S
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sensing pins, asynchronous
  input wire logic generator_ac_input,
  input wire logic near_charge_target,
  // Relays and indications
  output var gen_seq_pkg::relay_t relays,
  output logic ac_connect,
  output logic maintenance_charge_voltage,
  output logic start_error
);
  import gen_seq_pkg::*;

  // Two-stage synchronisers for the sense pins
  logic [1:0] ac_sync_reg;
  logic [1:0] tgt_sync_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ac_sync_reg <= 2'h0;
      tgt_sync_reg <= 2'h0;
    end else begin
      ac_sync_reg <= {ac_sync_reg[0], generator_ac_input};
      tgt_sync_reg <= {tgt_sync_reg[0], near_charge_target};
    end
  end
  wire ac_up = ac_sync_reg[1];
  wire at_target = tgt_sync_reg[1];

  // Timebase
  logic half_tick;
  logic sec_tick;
  half_sec_tick #(.HALF_CYC(HALF_CYC)) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .half_tick(half_tick),
    .sec_tick(sec_tick)
  );

  // Registers
  logic func_reg; // 1 = glow_and_halt_function
  logic start_req_reg;
  timing_t timing_reg;
  logic [15:0] sat_hold_reg;
  seq_state_t state_reg;
  seq_state_t state_next;
  logic [2:0] attempts_reg;
  logic [15:0] tmr_reg;
  logic [15:0] sat_cnt_reg;
  logic [8:0] run_cnt_reg;
  logic err_reg;
  logic manual_reg;
  logic tail_half_reg;
  relay_t relay_reg;
  relay_t relay_next;

  // APB decode; zero wait states
  wire wr = psel & penable & pwrite;
  wire hit_ctrl = (paddr == `OFF_CTRL);
  wire hit_tim = (paddr == `OFF_TIMING);
  wire hit_stat = (paddr == `OFF_STATUS);
  wire hit_chg = (paddr == `OFF_CHARGE);
  wire mapped = hit_ctrl | hit_tim | hit_stat | hit_chg;
  wire wr_ctrl = wr & hit_ctrl;
  wire go = wr_ctrl & pwrite & pwdata[`CTRL_START_BIT];
  wire auto_stop = wr_ctrl & pwdata[`CTRL_AUTO_STOP_BIT];
  wire man_stop = wr_ctrl & pwdata[`CTRL_MANUAL_STOP_BIT];
  wire err_clr = wr_ctrl & pwdata[`CTRL_ERR_CLR_BIT];
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // Read mux
  wire [31:0] rd_ctrl = {30'h0000_0000, start_req_reg, func_reg};
  wire [31:0] rd_tim = {8'h00, timing_reg};
  wire [31:0] rd_stat = {21'h00_0000, attempts_reg, 3'h0,
                         relay_reg.starter_relay, relay_reg.run_stop_relay,
                         err_reg, 1'(state_reg), 1'b0};
  wire [31:0] rd_chg = {16'h0000, sat_hold_reg};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= hit_ctrl ? rd_ctrl : hit_tim ? rd_tim :
                hit_stat ? rd_stat : hit_chg ? rd_chg : 32'h0000_0000;
    end
  end

  // Configuration writes; function resets to run-level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      func_reg <= 1'b0;
      timing_reg <= {`CRANK_LIMIT_RST, `GLOW_LEAD_RST, `RESTART_WAIT_RST};
      sat_hold_reg <= `SAT_HOLD_RST;
    end else begin
      // Function only changes while no start sequence is in flight
      if (wr_ctrl && (state_reg == ST_IDLE || state_reg == ST_STOPPED))
        func_reg <= pwdata[`CTRL_FUNC_BIT];
      if (wr & hit_tim)
        timing_reg <= pwdata[23:0];
      if (wr & hit_chg)
        sat_hold_reg <= pwdata[15:0];
    end
  end

  // Sequencer conditions
  wire tmr_zero = (tmr_reg == 16'h0000);
  wire glow_mode = func_reg;
  wire fails_out = (attempts_reg == `MAX_ATTEMPTS);
  wire sat_done = (sat_cnt_reg >= sat_hold_reg);
  wire stop_any = auto_stop | man_stop | (start_req_reg & sat_done);

  // Next state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (go && !err_reg)
          state_next = ST_GLOW;
      end
      ST_GLOW: begin
        if (tmr_zero)
          state_next = ST_CRANK;
      end
      ST_CRANK: begin
        if (ac_up)
          state_next = ST_CRANK_TAIL;
        else if (tmr_zero)
          state_next = ST_POST;
      end
      ST_CRANK_TAIL: begin
        if (half_tick)
          state_next = ST_POST;
      end
      ST_POST: begin
        if (tmr_zero)
          state_next = (ac_up) ? ST_KILL : ST_KILL;
      end
      ST_KILL: begin
        state_next = ST_KILL;
      end
      ST_COOL: begin
        if (tmr_zero)
          state_next = ST_STOPPED;
      end
      ST_STOPPED: begin
        if (go && !err_reg)
          state_next = ST_GLOW;
      end
    endcase
  end

  // Main sequencer; ST_KILL doubles as the running state
  logic running_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      tmr_reg <= 16'h0000;
      attempts_reg <= 3'h0;
      err_reg <= 1'b0;
      start_req_reg <= 1'b0;
      running_reg <= 1'b0;
      manual_reg <= 1'b0;
      tail_half_reg <= 1'b0;
    end else begin
      if (err_clr)
        err_reg <= 1'b0;
      if (sec_tick && !tmr_zero)
        tmr_reg <= tmr_reg - 16'h0001;
      unique case (state_reg)
        ST_IDLE, ST_STOPPED: begin
          manual_reg <= 1'b0;
          if (go && !err_reg) begin
            state_reg <= ST_GLOW;
            start_req_reg <= 1'b1;
            attempts_reg <= 3'h0;
            tmr_reg <= {8'h00, timing_reg.glow_lead};
          end
        end
        ST_GLOW: begin
          if (tmr_zero) begin
            state_reg <= ST_CRANK;
            attempts_reg <= attempts_reg + 3'h1;
            tmr_reg <= {8'h00, timing_reg.crank_limit};
          end
        end
        ST_CRANK: begin
          tail_half_reg <= 1'b0;
          if (ac_up) begin
            state_reg <= ST_CRANK_TAIL;
          end else if (tmr_zero) begin
            state_reg <= ST_POST;
            tmr_reg <= {8'h00, timing_reg.restart_wait_time};
          end
        end
        ST_CRANK_TAIL: begin
          // Second half tick, so the starter stays on a full half second
          if (half_tick) begin
            tail_half_reg <= 1'b1;
            if (tail_half_reg) begin
              state_reg <= ST_POST;
              tmr_reg <= {8'h00, timing_reg.restart_wait_time};
            end
          end
        end
        ST_POST: begin
          if (!ac_up && tmr_zero) begin
            // Failed attempt: retry or give up
            if (fails_out) begin
              state_reg <= ST_STOPPED;
              err_reg <= 1'b1;
              start_req_reg <= 1'b0;
            end else begin
              state_reg <= ST_GLOW;
              tmr_reg <= {8'h00, timing_reg.glow_lead};
            end
          end else if (ac_up && tmr_zero) begin
            state_reg <= ST_KILL;
            running_reg <= 1'b1;
          end
        end
        ST_KILL: begin
          if (man_stop) begin
            state_reg <= ST_STOPPED;
            manual_reg <= 1'b1;
            start_req_reg <= 1'b0;
            running_reg <= 1'b0;
          end else if (stop_any) begin
            state_reg <= ST_COOL;
            tmr_reg <= 16'(COOL_S);
          end else if (!ac_up) begin
            // Engine died: counts as a failed attempt
            running_reg <= 1'b0;
            state_reg <= fails_out ? ST_STOPPED : ST_GLOW;
            err_reg <= err_reg | fails_out;
            start_req_reg <= ~fails_out;
            tmr_reg <= {8'h00, timing_reg.glow_lead};
          end
          if (run_cnt_reg == 9'(RUN_OK))
            attempts_reg <= 3'h0;
        end
        ST_COOL: begin
          if (tmr_zero) begin
            state_reg <= ST_STOPPED;
            start_req_reg <= 1'b0;
            running_reg <= 1'b0;
          end
        end
      endcase
    end
  end

  // Run time and saturation counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_cnt_reg <= 9'h000;
      sat_cnt_reg <= 16'h0000;
    end else begin
      if (state_reg != ST_KILL)
        run_cnt_reg <= 9'h000;
      else if (sec_tick && run_cnt_reg != 9'(RUN_OK))
        run_cnt_reg <= run_cnt_reg + 9'h001;
      if (state_reg != ST_KILL || !at_target)
        sat_cnt_reg <= 16'h0000;
      else if (sec_tick && !sat_done)
        sat_cnt_reg <= sat_cnt_reg + 16'h0001;
    end
  end

  // Relay levels per state and function
  wire stop_phase = (state_reg == ST_STOPPED) & ~err_reg & ~running_reg
                    & (start_req_reg | manual_reg | glow_mode);
  always_comb begin
    relay_next.starter_relay = (state_reg == ST_CRANK) |
                               (state_reg == ST_CRANK_TAIL);
    if (glow_mode) begin
      relay_next.run_stop_relay = (state_reg == ST_GLOW) |
                                  ((state_reg == ST_STOPPED) & ac_up);
    end else begin
      // Run-level opens during glow to kill a spinning engine
      relay_next.run_stop_relay = (state_reg == ST_CRANK) |
                                  (state_reg == ST_CRANK_TAIL) |
                                  (state_reg == ST_POST) |
                                  (state_reg == ST_KILL) |
                                  (state_reg == ST_COOL);
    end
  end

  // Registered relay outputs, off from reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      relay_reg <= '0;
    else
      relay_reg <= relay_next;
  end

  // AC input connected only while running, dropped before a stop
  assign ac_connect = (state_reg == ST_KILL) & ~man_stop & ~stop_phase;
  // Still running after stop: hold maintenance charge
  assign maintenance_charge_voltage = (state_reg == ST_STOPPED) & ac_up;
  assign relays = relay_reg;
  assign start_error = err_reg;
endmodule
`default_nettype wire

// File: gen_seq_checker.sv
`timescale 1ns/1ps
`default_nettype none

module gen_seq_checker #(
  parameter int unsigned HALF_CYC = 4
) (
  // Clock, reset and APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Sensing and outputs
  input wire logic generator_ac_input,
  input wire gen_seq_pkg::relay_t relays,
  input wire logic maintenance_charge_voltage,
  input wire logic start_error
);
  import gen_seq_pkg::*;
  int unsigned crank_n;
  int unsigned ac_n;
  // Address decode of the access phase
  wire acc = psel && penable;
  wire bad = paddr > 12'h00C;
  wire good = paddr[11:4] == 8'h00 && paddr[1:0] == 2'h0;
  wire clr_wr = acc && pwrite && paddr == 12'h000 && pwdata[4];
  // Run lengths of cranking and of AC presence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crank_n <= 0;
      ac_n <= 0;
    end else begin
      crank_n <= relays.starter_relay ? crank_n + 1 : 0;
      ac_n <= generator_ac_input ? ac_n + 1 : 0;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_always: assert property (pready)
    else $error("pready low");
  a_crank_limit: assert property (crank_n <= 22 * HALF_CYC)
    else $error("crank too long");
  a_ac_release: assert property (
    ac_n > 4 * HALF_CYC + 4 |-> !relays.starter_relay)
    else $error("starter held with AC up");
  a_error_holds: assert property (
    start_error && !clr_wr |=> start_error)
    else $error("error dropped");
  a_error_quiet: assert property (
    start_error |-> !relays.starter_relay)
    else $error("crank after error");
  a_maint_quiet: assert property (
    maintenance_charge_voltage |-> !relays.starter_relay)
    else $error("crank while on float");
  a_slverr_bad: assert property (acc && bad |-> pslverr)
    else $error("unmapped not refused");
  a_slverr_good: assert property (acc && good |-> !pslverr)
    else $error("mapped refused");
  a_read_zero: assert property (
    acc && !pwrite && bad |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  c_crank: cover property ($rose(relays.starter_relay));
  c_error: cover property ($rose(start_error));
  c_float: cover property ($rose(maintenance_charge_voltage));
endmodule

bind gen_seq gen_seq_checker #(.HALF_CYC(HALF_CYC)) chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr),
  .generator_ac_input(generator_ac_input), .relays(relays),
  .maintenance_charge_voltage(maintenance_charge_voltage),
  .start_error(start_error));

`default_nettype wire

// File: engine_model.sv
`timescale 1ns/1ps
`default_nettype none

module engine_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Relays and test controls
  input wire gen_seq_pkg::relay_t relays,
  input wire logic glow_mode,
  input wire logic will_start,
  input wire logic ignore_stop,
  // Generator output as sensed
  output logic generator_ac_input
);
  import gen_seq_pkg::*;
  int crank_cnt;
  // Stop contact meaning flips with the selected function
  wire stop_cmd = glow_mode ? relays.run_stop_relay : !relays.run_stop_relay;
  // Engine catches after 12 cranking cycles; a stuck engine ignores stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crank_cnt <= 0;
      generator_ac_input <= 1'b0;
    end else begin
      crank_cnt <= relays.starter_relay ? crank_cnt + 1 : 0;
      if (will_start && crank_cnt == 12)
        generator_ac_input <= 1'b1;
      else if (stop_cmd && !ignore_stop && !relays.starter_relay)
        generator_ac_input <= 1'b0;
    end
  end
endmodule

`default_nettype wire

// File: tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import gen_seq_pkg::*;
  localparam int HC = 4;
  localparam int SEC = 2 * HC;
  localparam int COOL = 4;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] rd;
  logic err, near = 1'b0, glow = 1'b0, ok = 1'b0, ign = 1'b0, rs_d = 1'b0;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, ac, acc, mcv, serr;
  wire relay_t relays;
  wire logic [4:0] obs = {serr, mcv, acc, relays};
  int fails = 0, n_checks = 0, t, g, c, r, run_len = 0, kills = 0;
  int crank_q[$];
  // Clock
  always #2 pclk = ~pclk;
  gen_seq #(.HALF_CYC(HC), .COOL_S(COOL), .RUN_OK(20)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .generator_ac_input(ac),
    .near_charge_target(near), .relays(relays), .ac_connect(acc),
    .maintenance_charge_voltage(mcv), .start_error(serr));
  engine_model eng (.pclk(pclk), .presetn(presetn), .relays(relays),
    .glow_mode(glow), .will_start(ok), .ignore_stop(ign),
    .generator_ac_input(ac));
  // Attempt model: crank lengths and run relay drops
  always @(posedge pclk) begin
    rs_d <= relays.run_stop_relay;
    if (rs_d && !relays.run_stop_relay) kills <= kills + 1;
    if (relays.starter_relay) run_len <= run_len + 1;
    else if (run_len != 0) begin
      crank_q.push_back(run_len);
      run_len <= 0;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic rng(input int v, input int lo, input int hi, input string m);
    chk(32'(v >= lo && v <= hi), 32'h0000_0001, m);
  endtask
  // Bounded wait for one output bit, counting cycles
  task automatic wt(input int i, input logic v, input int lim, output int n);
    n = 0;
    while (obs[i] !== v && n < lim) begin
      @(posedge pclk);
      #1;
      n++;
    end
    if (n >= lim) chk(32'h0000_0000, 32'h0000_0001, "wait limit");
  endtask
  // One APB transfer; read data and error taken at the ready edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Start, crank, catch, and wait out the restart interval
  task automatic run_up(input logic [31:0] ctrl);
    apb(1'b1, 12'h000, ctrl);
    wt(0, 1'b1, 400, t);
    rng(t, (g - 1) * SEC, g * SEC + SEC, "glow lead");
    wt(0, 1'b0, 400, t);
    rng(t, 12, 12 + 2 * HC + 6, "starter release");
    repeat ((r + 1) * SEC) @(posedge pclk);
    #1 chk(obs[2:0], {2'h1, ~ctrl[0], 1'h0}, "running");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    #80000;
    fails++;
    final_report;
  end
  initial begin
    void'($urandom(56618));
    g = 2 + $urandom % 3;
    c = 3 + $urandom % 3;
    r = 2 + $urandom % 3;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (10) @(posedge pclk);
    #1 chk(obs, 32'h0000_0000, "idle outputs");
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk(rd[0], 1'h0, "func reset");
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk(rd[23:16], 8'h0A, "crank limit reset");
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk({err, rd}, {1'h1, 32'h0000_0000}, "unmapped");
    apb(1'b1, 12'h004, {8'h00, 8'(c), 8'(g), 8'(r)});
    ok = 1'b1;
    run_up(32'h0000_0002);
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk(rd[10:8], 3'h1, "one attempt");
    repeat (21 * SEC) @(posedge pclk);
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk(rd[10:8], 3'h0, "attempts cleared");
    apb(1'b1, 12'h000, 32'h0000_0004);
    wt(1, 1'b0, 400, t);
    rng(t, (COOL - 1) * SEC, COOL * SEC + SEC, "cool down");
    // Engine that never catches
    ok = 1'b0;
    kills = 0;
    crank_q.delete();
    apb(1'b1, 12'h000, 32'h0000_0002);
    wt(4, 1'b1, 5 * (g + c + r + 3) * SEC, t);
    chk(crank_q.size(), 5, "attempt count");
    foreach (crank_q[i]) rng(crank_q[i], (c - 1) * SEC, c * SEC + SEC, "crank");
    rng(kills, 4, 5, "kill before retry");
    apb(1'b1, 12'h000, 32'h0000_0010);
    #1 chk(obs[4], 1'h0, "error cleared");
    // Glow-and-halt with manual stop
    ok = 1'b1;
    glow = 1'b1;
    apb(1'b1, 12'h000, 32'h0000_0001);
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk(rd[0], 1'h1, "func set");
    apb(1'b1, 12'h000, 32'h0000_0003);
    repeat (SEC) @(posedge pclk);
    #1 chk(obs[1:0], 2'h2, "glow signal");
    g = g - 1;
    run_up(32'h0000_0003);
    g = g + 1;
    apb(1'b1, 12'h000, 32'h0000_0009);
    wt(1, 1'b1, 20, t);
    rng(t, 0, 8, "manual stop");
    chk(obs[2], 1'h0, "disconnect first");
    // Saturation-hold stop on an engine that will not stop
    wt(2, 1'b0, 100, t);
    apb(1'b1, 12'h00C, 32'h0000_0002);
    run_up(32'h0000_0003);
    ign = 1'b1;
    @(posedge pclk);
    near <= 1'b1;
    wt(1, 1'b1, 20 * SEC, t);
    rng(t, COOL * SEC, (COOL + 3) * SEC + 4, "saturation stop");
    repeat (SEC) @(posedge pclk);
    #1 chk(obs[3], 1'h1, "float charge");
    final_report;
  end
endmodule

`default_nettype wire
